/* File: bpsc_params.svh */
// Contract
// - Backup only below battery-hyst and, outside direct mode, below trip
// - Return when above battery+hyst, or trip+hyst outside direct mode
// - Serial bus disabled while on backup
// - Timekeeping and other pins keep running
// - Total power loss flag in status 0Bh
// - Direct-switch bit 5 of 08h stops trip monitor
// - Direct mode switches on battery compare only
// - Direct-switch bit resets to zero
// - Sealed: no battery draw before main seen
// - Re-arm bit writes return to sealed state from main only
// - Dual pin: 512Hz or level per 07h
`ifndef BPSC_PARAMS_SVH
`define BPSC_PARAMS_SVH
`define BPSC_ADDR_TRIM 5'h07
`define BPSC_ADDR_INT 5'h08
`define BPSC_ADDR_STATUS 5'h0b
`define BPSC_ADDR_IRQ_STAT 5'h1c
`define BPSC_ADDR_IRQ_MASK 5'h1d
`define BPSC_ADDR_PWR 5'h1e
`define BPSC_BIT_OUT 7
`define BPSC_BIT_FT 6
`define BPSC_BIT_LPM 5
`define BPSC_BIT_BATTERY_SAVER_REARM 5
`define BPSC_BIT_BAT 1
`define BPSC_BIT_TPL 0
`define BPSC_TRIM_RESET 8'h80
`define BPSC_INT_RESET 8'h00
`define BPSC_CLK_HZ 25000000
`define BPSC_FT_HZ 512
`define BPSC_FT_HALF ((`BPSC_CLK_HZ / `BPSC_FT_HZ) / 2)
`endif

/* File: bpsc_pkg.sv */
package bpsc_pkg;
   // Supply state of the switch
   typedef enum logic [1:0] {SEALED, MAIN, BACKUP} bpsc_state_t;
   // Comparator bundle from the analog side
   typedef struct packed {
      logic mainBelowBatHys;  // Main < backup - hysteresis
      logic mainAboveBatHys;  // Main > backup + hysteresis
      logic mainBelowTrip;    // Main < trip threshold
      logic mainAboveTripHys; // Main > trip + trip hysteresis
      logic mainPresent;      // Main supply seen at all
   } bpsc_cmp_t;
   // Register bus request
   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bpsc_bus_t;
endpackage : bpsc_pkg

/* File: bpsc_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser for a vector of levels
module bpsc_sync #(parameter int W = 5)
(
   input wire clk_sys,
   input wire reset_n,
   input wire [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] stage1; // First stage, read only by stage two
   // Register both stages
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stage1 <= '0;
         dout <= '0;
      end
      else
      begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule : bpsc_sync

/* File: bpsc_freq_gen.sv */
`timescale 1ns/1ps
`include "bpsc_params.svh"
// Square wave divider for the compensation frequency
module bpsc_freq_gen #(parameter int HALF = `BPSC_FT_HALF)
(
   input wire clk_sys,
   input wire reset_n,
   output logic wave
);
   logic [15:0] count; // Half-period counter
   logic [15:0] next_count; // Next counter value
   logic next_wave; // Next wave level
   // Count half periods and toggle
   always_comb
   begin
      next_count = count + 16'h0001;
      next_wave = wave;
      if (count >= 16'(HALF - 1))
      begin
         next_count = 16'h0000;
         next_wave = ~wave;
      end
   end
   // Register the divider
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count <= 16'h0000;
         wave <= 1'b0;
      end
      else
      begin
         count <= next_count;
         wave <= next_wave;
      end
   end
endmodule : bpsc_freq_gen

/* File: backup_power_switch_control.sv */
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "bpsc_params.svh"
// Backup supply switch control with register port
module backup_power_switch_control
   import bpsc_pkg::*;
(
   input wire clk_sys,
   input wire reset_n,
   input wire bpsc_cmp_t cmpIn,
   input wire [4:0] regAddr,
   input wire [7:0] regWdata,
   input wire regWr,
   input wire regRd,
   output logic [7:0] regRdata,
   output logic onBackup,
   output logic batteryDrawEn,
   output logic busEnable,
   output logic timekeepEnable,
   output logic tripMonitorEn,
   output logic dualPinOut,
   output logic dualPinOe_n,
   output logic irq
);
   bpsc_cmp_t cmpSync; // Synchronised comparator levels
   logic ftWave; // 512Hz square wave
   bpsc_state_t state; // Supply state
   bpsc_state_t next_state;
   logic [7:0] trimReg; // Output and frequency select
   logic [7:0] next_trimReg;
   logic lowPower; // Direct switch select
   logic next_lowPower;
   logic lossFlag; // Total power loss flag
   logic next_lossFlag;
   logic [1:0] irqStat; // Sticky events: bit0 to backup, bit1 to main
   logic [1:0] next_irqStat;
   logic [1:0] irqMask; // Interrupt mask
   logic [1:0] next_irqMask;
   logic [7:0] next_regRdata;
   logic toBackup; // Switch-over event this cycle
   logic toMain; // Return event this cycle
   logic wrHit; // Write decode helper
   bpsc_bus_t bus; // Bundled request

   assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

   // Write decode
   function automatic logic wrAt(input bpsc_bus_t b, input logic [4:0] a);
      wrAt = b.wr && (b.addr == a);
   endfunction : wrAt

   // Comparator inputs cross from the analog domain
   bpsc_sync #(.W($bits(bpsc_cmp_t))) uSync
   (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .din(cmpIn),
      .dout(cmpSync)
   );

   // Compensation frequency source
   bpsc_freq_gen #(.HALF(`BPSC_FT_HALF)) uFreq
   (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .wave(ftWave)
   );

   // Supply state machine
   always_comb
   begin
      next_state = state;
      toBackup = 1'b0;
      toMain = 1'b0;
      case (state)
         SEALED:
         begin
            // No battery draw until main supply appears
            if (cmpSync.mainPresent)
               next_state = MAIN;
         end
         MAIN:
         begin
            if (wrAt(bus, `BPSC_ADDR_STATUS) && regWdata[`BPSC_BIT_BATTERY_SAVER_REARM])
               next_state = SEALED;
            else if (lowPower)
            begin
               // Direct mode ignores trip threshold
               if (cmpSync.mainBelowBatHys)
               begin
                  next_state = BACKUP;
                  toBackup = 1'b1;
               end
            end
            else if (cmpSync.mainBelowBatHys && cmpSync.mainBelowTrip)
            begin
               next_state = BACKUP;
               toBackup = 1'b1;
            end
         end
         BACKUP:
         begin
            // Either condition returns to main; in direct mode only battery plus hysteresis
            if (cmpSync.mainAboveBatHys || (!lowPower && cmpSync.mainAboveTripHys))
            begin
               next_state = MAIN;
               toMain = 1'b1;
            end
         end
         default:
            next_state = SEALED;
      endcase
   end

   // Register the supply state
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         state <= SEALED;
      else
         state <= next_state;
   end

   // Register file next values
   always_comb
   begin
      next_trimReg = trimReg;
      next_lowPower = lowPower;
      next_lossFlag = lossFlag;
      next_irqMask = irqMask;
      next_irqStat = irqStat;
      next_regRdata = 8'h00;
      if (wrAt(bus, `BPSC_ADDR_TRIM))
         next_trimReg = regWdata;
      if (wrAt(bus, `BPSC_ADDR_INT))
         next_lowPower = regWdata[`BPSC_BIT_LPM];
      // Software clears the loss flag by writing zero
      if (wrAt(bus, `BPSC_ADDR_STATUS) && !regWdata[`BPSC_BIT_TPL])
         next_lossFlag = 1'b0;
      if (wrAt(bus, `BPSC_ADDR_IRQ_MASK))
         next_irqMask = regWdata[1:0];
      // Reads
      if (bus.rd)
      begin
         case (bus.addr)
            `BPSC_ADDR_TRIM: next_regRdata = trimReg;
            `BPSC_ADDR_INT: next_regRdata = {2'b00, lowPower, 5'b00000};
            `BPSC_ADDR_STATUS: next_regRdata = {6'b000000, state == BACKUP, lossFlag};
            `BPSC_ADDR_IRQ_STAT: next_regRdata = {6'b000000, irqStat};
            `BPSC_ADDR_IRQ_MASK: next_regRdata = {6'b000000, irqMask};
            `BPSC_ADDR_PWR: next_regRdata = {6'b000000, state};
            default: next_regRdata = 8'h00;
         endcase
         if (bus.addr == `BPSC_ADDR_IRQ_STAT)
            next_irqStat = 2'b00;
      end
      // Events set after the read clear so a set wins
      if (toBackup)
         next_irqStat[0] = 1'b1;
      if (toMain)
         next_irqStat[1] = 1'b1;
   end

   // Register file storage; loss flag set by power-up reset
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         trimReg <= `BPSC_TRIM_RESET;
         lowPower <= 1'b0;
         lossFlag <= 1'b1;
         irqStat <= 2'b00;
         irqMask <= 2'b00;
         regRdata <= 8'h00;
      end
      else
      begin
         trimReg <= next_trimReg;
         lowPower <= next_lowPower;
         lossFlag <= next_lossFlag;
         irqStat <= next_irqStat;
         irqMask <= next_irqMask;
         regRdata <= next_regRdata;
      end
   end

   // Outputs derived from state and register bits
   assign onBackup = (state == BACKUP);
   assign batteryDrawEn = (state != SEALED);
   assign busEnable = (state != BACKUP);
   assign timekeepEnable = 1'b1;
   assign tripMonitorEn = !lowPower;
   assign irq = |(irqStat & irqMask);
   // Open drain: enable low pulls pin low when output is zero
   assign dualPinOut = 1'b0;
   assign dualPinOe_n = trimReg[`BPSC_BIT_FT] ? ftWave : trimReg[`BPSC_BIT_OUT];

   // Switch-over needs both conditions in normal mode
   sequence seqNormalDrop;
      state == MAIN && !lowPower && !(cmpSync.mainBelowBatHys && cmpSync.mainBelowTrip);
   endsequence
   AST_NO_EARLY_BACKUP: assert property (@(posedge clk_sys) disable iff (!reset_n)
      seqNormalDrop |=> state != BACKUP) else $error("backup entered without both conditions");
   AST_RETURN_MAIN: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state == BACKUP && cmpSync.mainAboveBatHys |=> state == MAIN) else $error("no return to main");
   AST_BUS_OFF: assert property (@(posedge clk_sys) disable iff (!reset_n)
      onBackup |-> !busEnable) else $error("bus active on backup");
   AST_TIMEKEEP: assert property (@(posedge clk_sys) disable iff (!reset_n)
      timekeepEnable) else $error("timekeeping stopped");
   AST_FLAG_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)
      bus.rd && bus.addr == `BPSC_ADDR_STATUS |=> regRdata[0] == $past(lossFlag)) else $error("flag read wrong");
   AST_FLAG_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
      lossFlag && !wrAt(bus, `BPSC_ADDR_STATUS) |=> lossFlag) else $error("loss flag dropped");
   AST_LPM_TRIP: assert property (@(posedge clk_sys) disable iff (!reset_n)
      lowPower |-> !tripMonitorEn) else $error("trip monitor on in direct mode");
   AST_LPM_SWITCH: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state == MAIN && lowPower && cmpSync.mainBelowBatHys && !bus.wr |=> onBackup) else $error("direct switch missed");
   AST_SEALED: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state == SEALED && !cmpSync.mainPresent |=> !batteryDrawEn) else $error("sealed drew battery");
   AST_BATTERY_SAVER_REARM: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state == MAIN && wrAt(bus, `BPSC_ADDR_STATUS) && regWdata[`BPSC_BIT_BATTERY_SAVER_REARM] |=> state == SEALED)
      else $error("re-arm ignored");
   AST_PIN_LEVEL: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !trimReg[`BPSC_BIT_FT] |-> dualPinOe_n == trimReg[`BPSC_BIT_OUT]) else $error("pin level wrong");
endmodule : backup_power_switch_control

/* File: bpsc_supply_model.sv */
`timescale 1ns/1ps
// Analog comparators facing the control logic, supplies in mV
module bpsc_supply_model
   import bpsc_pkg::*;
#(
   parameter int BAT_HYS = 50,
   parameter int TRIP = 2600,
   parameter int TRIP_HYS = 30
)
(
   input int vMain,
   input int vBat,
   output bpsc_cmp_t cmp
);
   // Comparator levels follow the supplies at once
   always_comb
   begin
      cmp.mainBelowBatHys = vMain < vBat - BAT_HYS; // Leave main
      cmp.mainAboveBatHys = vMain > vBat + BAT_HYS; // Back to main
      cmp.mainBelowTrip = vMain < TRIP; // Trip
      cmp.mainAboveTripHys = vMain > TRIP + TRIP_HYS; // Trip return
      cmp.mainPresent = vMain > 0; // Main seen
   end
endmodule : bpsc_supply_model

/* File: backup_power_switch_control_tb.sv */
`timescale 1ns/1ps
`include "bpsc_params.svh"
// Self-checking bench for the supply switch control
module backup_power_switch_control_tb
   import bpsc_pkg::*;
;
   logic clk_sys = 1'b0; // 25 MHz clock
   logic reset_n = 1'b0; // Power-up reset
   int vMain = 0; // Main supply
   int vBat = 3000; // Backup supply
   bpsc_cmp_t cmpIn; // Comparator levels
   logic [4:0] regAddr = 5'h00;
   logic [7:0] regWdata = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regRdata;
   logic [7:0] rv; // Last read value
   logic onBackup, batteryDrawEn, busEnable, timekeepEnable, tripMonitorEn, dualPinOut, dualPinOe_n, irq;
   int err_total = 0;
   int checked = 0;
   int cycles = 0; // Run length for the hang guard
   always #20 clk_sys = ~clk_sys;
   bpsc_supply_model u_supply (.vMain(vMain), .vBat(vBat), .cmp(cmpIn));
   backup_power_switch_control u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .cmpIn(cmpIn), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .onBackup(onBackup),
      .batteryDrawEn(batteryDrawEn), .busEnable(busEnable), .timekeepEnable(timekeepEnable),
      .tripMonitorEn(tripMonitorEn), .dualPinOut(dualPinOut), .dualPinOe_n(dualPinOe_n), .irq(irq));
   // Counts and reports one comparison
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One-cycle register write
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask : wr
   // One-cycle register read, data taken in the following cycle
   task automatic rd(input logic [4:0] a);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 rv = regRdata;
   endtask : rd
   // Moves the main supply and lets sync and state settle
   task automatic sup(input int m);
      @(posedge clk_sys);
      vMain <= m;
      repeat (6) @(posedge clk_sys);
      #1;
   endtask : sup
   // Closing report
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict
   // Hang guard
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         err_total++;
         print_verdict();
      end
   end
   // Main sequence
   initial
   begin
      int n;
      logic lvl;
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd(5'h0b);
      chk("status", 16'h0001, 16'(rv)); // Loss flag after power-up
      rd(5'h08);
      chk("int", 16'h0000, 16'(rv)); // Direct switch off
      rd(5'h07);
      chk("trim", 16'h0080, 16'(rv)); // Pin level default
      chk("tripMon", 16'h0001, 16'(tripMonitorEn)); // Trip watch on
      chk("pinOe", 16'h0001, 16'(dualPinOe_n)); // Pin released
      sup(0);
      chk("draw", 16'h0000, 16'(batteryDrawEn)); // Sealed, no draw
      chk("backup", 16'h0000, 16'(onBackup)); // Sealed stays off battery
      sup(3300);
      chk("draw", 16'h0001, 16'(batteryDrawEn)); // Unsealed by main
      $display("test seal done");
      wr(5'h1d, 8'h01);
      rd(5'h1c);
      sup(2900);
      chk("backup", 16'h0000, 16'(onBackup)); // Above trip holds main
      sup(2500);
      chk("backup", 16'h0001, 16'(onBackup)); // Both below
      chk("bus", 16'h0000, 16'(busEnable)); // Bus off on battery
      chk("time", 16'h0001, 16'(timekeepEnable)); // Timekeeping runs
      chk("irq", 16'h0001, 16'(irq)); // Entry event unmasked
      rd(5'h0b);
      chk("status", 16'h0003, 16'(rv)); // Backup and loss bits
      rd(5'h1c);
      chk("irqStat", 16'h0001, 16'(rv)); // Entry event seen
      #1 chk("irq", 16'h0000, 16'(irq)); // Cleared by read
      wr(5'h1d, 8'h00);
      sup(2640);
      chk("backup", 16'h0000, 16'(onBackup)); // Trip plus hysteresis
      chk("bus", 16'h0001, 16'(busEnable)); // Bus back on main
      chk("irq", 16'h0000, 16'(irq)); // Return event masked
      rd(5'h1c);
      chk("irqStat", 16'h0002, 16'(rv)); // Return event still latched
      rd(5'h1e);
      chk("stateCode", 16'h0001, 16'(rv)); // Back in main
      chk("pinOut", 16'h0000, 16'(dualPinOut)); // Open drain drives low only
      $display("test normal done");
      wr(5'h08, 8'h20);
      #1 chk("tripMon", 16'h0000, 16'(tripMonitorEn)); // Trip watch off
      sup(2900);
      chk("backup", 16'h0001, 16'(onBackup)); // Battery compare only
      sup(2700);
      chk("backup", 16'h0001, 16'(onBackup)); // Trip ignored on return
      sup(3100);
      chk("backup", 16'h0000, 16'(onBackup)); // Battery plus hysteresis
      wr(5'h08, 8'h00);
      $display("test direct done");
      wr(5'h0b, 8'h01);
      rd(5'h0b);
      chk("status", 16'h0001, 16'(rv)); // Writing one keeps flag
      wr(5'h0b, 8'h00);
      rd(5'h0b);
      chk("status", 16'h0000, 16'(rv)); // Software clears flag
      wr(5'h0b, 8'h20);
      #1 chk("draw", 16'h0000, 16'(batteryDrawEn)); // Resealed
      $display("test flag done");
      wr(5'h07, 8'h00);
      #1 chk("pinOe", 16'h0000, 16'(dualPinOe_n)); // Level low
      wr(5'h07, 8'h40);
      @(negedge clk_sys);
      for (int k = 0; k < 2; k++)
      begin
         n = 0;
         lvl = dualPinOe_n;
         while (dualPinOe_n === lvl && n < 30000)
         begin
            @(negedge clk_sys);
            n++;
         end
      end
      chk("ftHalf", 16'(`BPSC_FT_HALF), 16'(n)); // 512Hz half period
      $display("test pin done");
      print_verdict();
   end
endmodule : backup_power_switch_control_tb
